// >>> core/csel_pkg.sv
// Constants and carriers for the control source selector.
// Assumes a single 20 MHz clock domain and an AXI4-Lite register bus.
package csel_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_CFG = 4'h0; // Selection and mode settings
  localparam logic [3:0] OFF_CMD = 4'h4; // Host command bits, one per code
  localparam logic [3:0] OFF_ROUTED = 4'h8; // Routed function levels
  localparam logic [3:0] OFF_FLAG = 4'hC; // Halt and link refusal state

  // Bus responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Source selection values
  localparam logic SEL_HOST = 1'h0;
  localparam logic SEL_EXT = 1'h1;

  // Mode parameter values
  localparam logic [1:0] REMOTE_MODE_A = 2'h1;
  localparam logic [1:0] REMOTE_MODE_B = 2'h2;
  localparam logic [2:0] OPMODE_PROGRAM = 3'h5;
  localparam logic [2:0] OPMODE_INTERLOCK = 3'h7;
  localparam logic [1:0] STOP_MODE_A = 2'h1;
  localparam logic [1:0] STOP_MODE_B = 2'h3;
  localparam logic COMP_ON = 1'h1;
  localparam logic [1:0] REGEN_CONVERTER = 2'h2;
  localparam logic [1:0] HALT_POL_ANY = 2'h0;
  localparam logic [1:0] HALT_POL_BOTH = 2'h2;

  // Input function codes (bit index in command and terminal words)
  localparam int FC_LOW_SPEED = 0;
  localparam int FC_MID_SPEED = 1;
  localparam int FC_HIGH_SPEED = 2;
  localparam int FC_SECOND_FUNC = 3;
  localparam int FC_THERMAL = 7;
  localparam int FC_FIFTEEN_SPEED = 8;
  localparam int FC_THIRD_FUNC = 9;
  localparam int FC_CONV_RUN = 10;
  localparam int FC_CONV_PFAIL = 11;
  localparam int FC_PANEL_ILK = 12;
  localparam int FC_DC_BRAKE = 13;
  localparam int FC_PID = 14;
  localparam int FC_BRAKE_DONE = 15;
  localparam int FC_PANEL_SWITCH = 16;
  localparam int FC_LOAD_PATTERN = 17;
  localparam int FC_FLUX_VF = 18;
  localparam int FC_TORQUE_HS = 19;
  localparam int FC_S_CURVE = 20;
  localparam int FC_ORIENT = 22;
  localparam int FC_PRE_EXCITE = 23;
  localparam int FC_OUTPUT_HALT = 24;
  localparam int FC_SPARE = 31;
  localparam int FC_COUNT = 32;

  // Configuration register layout, low bit first at the bottom
  typedef struct packed {
    logic interlock_assigned; // [15] Interlock input is assigned
    logic run_enable_assigned; // [14] Run-enable input is assigned
    logic [1:0] halt_polarity_select; // [13:12]
    logic [1:0] regen_converter_select; // [11:10]
    logic multi_speed_compensation; // [9]
    logic [1:0] stop_on_contact_mode; // [8:7]
    logic [2:0] operation_mode_param; // [6:4]
    logic [1:0] remote_setting_mode; // [3:2]
    logic speed_source_select; // [1]
    logic operation_source_select; // [0]
  } csel_cfg_s;

  localparam int CFG_W = 16;
  localparam logic [15:0] CFG_RST = 16'h0000; // Both sources on host
  localparam logic [31:0] CMD_RST = 32'h0000_0000;

endpackage

// >>> core/csel_top.sv
// Control source selector: routes each input function from host or terminals.
// Assumes clk at 20 MHz, synchronous active-high reset, AXI4-Lite master.
//
// Contract
// RL1: Two one-bit selections, 0 host, 1 terminals
// RL2: Thermal relay input always from terminals
// RL3: Codes 10, 11, 12, 16 always from terminals
// RL4: Operation-group codes follow operation source selection
// RL5: PID enable and fifteen-speed follow speed source
// RL6: Remote mode 1/2: remote inputs follow speed source
// RL7: Program mode 5: group inputs blocked, link refused
// RL8: Stop-on-contact 1/3: select0 speed, select1 operation
// RL9: Both-source functions honour host or terminal
// RL10: Unavailable functions ignore both sources
// RL11: Compensation inputs take terminal only when enabled
// RL12: Unassigned converter or interlock forces terminal halt
// RL13: Polarity 0: halt when either request on
// RL14: Polarity 2: run only when both on
// RL15: Setting changes reroute live, no restart
`timescale 1ns/1ns
`default_nettype none

module csel_top (
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Terminal inputs, one per function code, asynchronous
  input wire logic [31:0] term_in,
  // Routed function levels toward the drive
  output logic [31:0] func_out,
  // Drive output halt, high stops output
  output logic output_halt,
  // Host link operation refused
  output logic link_refused
);

  ////////////////////////////////////////////////////////////////////////
  // State

  csel_pkg::csel_cfg_s cfg; // Live settings
  logic [31:0] cmd; // Host command bits
  logic [31:0] term_m; // Synchroniser first stage
  logic [31:0] term_s; // Synchronised terminal levels
  logic [31:0] next_func; // Routed levels before register
  logic next_halt; // Halt before register
  logic wr_go; // Write address and data both present
  logic rd_go; // Read address present

  ////////////////////////////////////////////////////////////////////////
  // Terminal synchroniser

  // Two stages before anything reads the pins
  always_ff @(posedge clk)
  begin
    term_m <= term_in;
    term_s <= term_m;
  end

  ////////////////////////////////////////////////////////////////////////
  // Routing

  // Route one function code from host bit or terminal bit
  function automatic logic route_bit(input int code, input csel_pkg::csel_cfg_s c,
                                     input logic hb, input logic tb);
    logic spd;
    logic opr;
    logic blocked;
    spd = (c.speed_source_select == csel_pkg::SEL_EXT) ? tb : hb; // see RL1
    opr = (c.operation_source_select == csel_pkg::SEL_EXT) ? tb : hb; // see RL1
    blocked = (c.operation_mode_param == csel_pkg::OPMODE_PROGRAM);
    case (code)
      // Fixed to the terminals
      csel_pkg::FC_THERMAL: route_bit = tb; // see RL2
      csel_pkg::FC_CONV_RUN, csel_pkg::FC_CONV_PFAIL, csel_pkg::FC_PANEL_ILK,
      csel_pkg::FC_PANEL_SWITCH: route_bit = tb; // see RL3
      // Speed-source group
      csel_pkg::FC_FIFTEEN_SPEED, csel_pkg::FC_PID: route_bit = spd; // see RL5
      // Operation-source group
      csel_pkg::FC_THIRD_FUNC, csel_pkg::FC_DC_BRAKE, csel_pkg::FC_BRAKE_DONE,
      csel_pkg::FC_LOAD_PATTERN, csel_pkg::FC_FLUX_VF, csel_pkg::FC_TORQUE_HS,
      csel_pkg::FC_S_CURVE, csel_pkg::FC_ORIENT, csel_pkg::FC_PRE_EXCITE:
        route_bit = opr; // see RL4
      // Second function and stop-on-contact select 1 follow operation
      csel_pkg::FC_SECOND_FUNC: route_bit = opr; // see RL8
      // Multi-speed, remote and stop-on-contact select 0
      csel_pkg::FC_LOW_SPEED, csel_pkg::FC_MID_SPEED, csel_pkg::FC_HIGH_SPEED:
      begin
        if (blocked)
        begin
          // Program group inputs taken from neither side
          route_bit = 1'b0; // see RL7
        end
        else if (c.speed_source_select == csel_pkg::SEL_EXT)
        begin
          // Remote setting and stop-on-contact follow speed source
          route_bit = tb; // see RL6 RL8
        end
        else if (code == csel_pkg::FC_LOW_SPEED &&
                 (c.stop_on_contact_mode == csel_pkg::STOP_MODE_A ||
                  c.stop_on_contact_mode == csel_pkg::STOP_MODE_B))
        begin
          // Stop-on-contact select 0 from host only, terminal never mixed in
          route_bit = hb; // see RL8
        end
        else if (c.remote_setting_mode == csel_pkg::REMOTE_MODE_A ||
                 c.remote_setting_mode == csel_pkg::REMOTE_MODE_B)
        begin
          // Remote setting from host only
          route_bit = hb; // see RL6
        end
        else
        begin
          // Host speeds, terminal adds in only with compensation on
          route_bit = hb | ((c.multi_speed_compensation == csel_pkg::COMP_ON) & tb); // see RL11
        end
      end
      // Anything else is unavailable from both sides
      default: route_bit = 1'b0; // see RL10
    endcase
  endfunction

  // One router per function code, reading live settings
  for (genvar i = 0; i < csel_pkg::FC_COUNT; i++)
  begin : g_route
    assign next_func[i] = route_bit(i, cfg, cmd[i], term_s[i]); // see RL15
  end

  // Output halt merge
  always_comb
  begin
    next_halt = 1'b0;
    if ((cfg.regen_converter_select == csel_pkg::REGEN_CONVERTER && !cfg.run_enable_assigned) ||
        (cfg.operation_mode_param == csel_pkg::OPMODE_INTERLOCK && !cfg.interlock_assigned) ||
        cfg.operation_source_select == csel_pkg::SEL_EXT)
    begin
      // Terminal only
      next_halt = term_s[csel_pkg::FC_OUTPUT_HALT]; // see RL12
    end
    else if (cfg.halt_polarity_select == csel_pkg::HALT_POL_BOTH)
    begin
      // Run only while both are on
      next_halt = !(cmd[csel_pkg::FC_OUTPUT_HALT] & term_s[csel_pkg::FC_OUTPUT_HALT]); // see RL14
    end
    else
    begin
      // Either side stops output
      next_halt = cmd[csel_pkg::FC_OUTPUT_HALT] | term_s[csel_pkg::FC_OUTPUT_HALT]; // see RL9 RL13
    end
  end

  // Registered drive-facing outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      func_out <= 32'h0000_0000;
      output_halt <= 1'b0;
      link_refused <= 1'b0;
    end
    else
    begin
      func_out <= next_func;
      output_halt <= next_halt;
      link_refused <= (cfg.operation_mode_param == csel_pkg::OPMODE_PROGRAM); // see RL7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;

  // Accept address and data together, then answer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= csel_pkg::RESP_OK;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (s_axi_awready)
      begin
        // Taken this edge
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr == csel_pkg::OFF_CFG || s_axi_awaddr == csel_pkg::OFF_CMD)
                       ? csel_pkg::RESP_OK : csel_pkg::RESP_DECERR;
      end
      else if (s_axi_bready)
      begin
        // Response consumed
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Settings and host commands, byte lanes honoured
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg <= csel_pkg::CFG_RST; // see RL1
      cmd <= csel_pkg::CMD_RST;
    end
    else if (s_axi_awready)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (s_axi_wstrb[b] && s_axi_awaddr == csel_pkg::OFF_CMD)
        begin
          cmd[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
        end
      end
      // Only the two low lanes exist in the settings word, so no slice runs past it
      for (int b = 0; b < 2; b++)
      begin
        if (s_axi_wstrb[b] && s_axi_awaddr == csel_pkg::OFF_CFG)
        begin
          cfg[b*8 +: 8] <= s_axi_wdata[b*8 +: 8]; // see RL15
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  // One read at a time, data registered with the answer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= csel_pkg::RESP_OK;
    end
    else
    begin
      s_axi_arready <= rd_go;
      if (s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= csel_pkg::RESP_OK;
        case (s_axi_araddr)
          csel_pkg::OFF_CFG: s_axi_rdata <= {16'h0000, cfg};
          csel_pkg::OFF_CMD: s_axi_rdata <= cmd;
          csel_pkg::OFF_ROUTED: s_axi_rdata <= func_out;
          csel_pkg::OFF_FLAG: s_axi_rdata <= {30'h0000_0000, link_refused, output_halt};
          default:
          begin
            // Unmapped reads zero with decode error
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= csel_pkg::RESP_DECERR;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence

  sequence s_wr_answer;
    s_axi_bvalid [*1];
  endsequence

  a_bus_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write not answered next cycle");

  a_thermal_fixed: assert property (1 |=> func_out[7] == $past(term_s[7])) // see RL2
    else $error("thermal input not from terminal");

  a_fixed_terminal: assert property (1 |=> func_out[16] == $past(term_s[16]) &&
                                     func_out[10] == $past(term_s[10])) // see RL3
    else $error("fixed input not from terminal");

  a_oper_follow: assert property (!cfg.operation_source_select |=> func_out[9] == $past(cmd[9])) // see RL4
    else $error("operation group not from host");

  a_speed_follow: assert property (cfg.speed_source_select |=> func_out[14] == $past(term_s[14])) // see RL5
    else $error("pid enable not from terminal");

  a_remote_host: assert property (cfg.remote_setting_mode == 2'h2 && !cfg.speed_source_select &&
                                  cfg.operation_mode_param != 3'h5 |=> func_out[1] == $past(cmd[1])) // see RL6
    else $error("remote input not from host");

  // Stop-on-contact select 0 ignores the terminal while the speed source is host
  a_stop_select: assert property ( // see RL8
    (cfg.stop_on_contact_mode == 2'h1 || cfg.stop_on_contact_mode == 2'h3) &&
    !cfg.speed_source_select && cfg.operation_mode_param != 3'h5 |=> func_out[0] == $past(cmd[0]))
    else $error("stop-on-contact select 0 not from host");

  a_program_block: assert property (cfg.operation_mode_param == 3'h5 [*2] |-> link_refused &&
                                    func_out[2:0] == 3'h0) // see RL7
    else $error("program group not blocked");

  a_unavailable: assert property (1 |=> !func_out[31] && !func_out[24]) // see RL10
    else $error("unavailable function passed");

  a_halt_force: assert property (cfg.regen_converter_select == 2'h2 && !cfg.run_enable_assigned
                                 |=> output_halt == $past(term_s[24])) // see RL12
    else $error("halt not forced to terminal");

  a_halt_any: assert property (!cfg.operation_source_select && cfg.halt_polarity_select == 2'h0 &&
                               cfg.regen_converter_select != 2'h2 && cfg.operation_mode_param != 3'h7
                               && cmd[24] |=> output_halt) // see RL13
    else $error("host halt ignored");

  a_halt_both: assert property (!cfg.operation_source_select && cfg.halt_polarity_select == 2'h2 &&
                                cfg.regen_converter_select != 2'h2 && cfg.operation_mode_param != 3'h7
                                && !cmd[24] |=> output_halt) // see RL14
    else $error("halt not asserted under both-on polarity");

endmodule // csel_top

`default_nettype wire

// >>> dv/csel_term_model.sv
// Terminal-side model: presents the requested contact levels on the terminal pins.
// Assumes the bench asks for new levels just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module csel_term_model (
  input wire logic clk,
  input wire logic [31:0] want,
  output logic [31:0] term_in
);
  // Contacts start open so nothing is asserted before the bench asks
  initial term_in = 32'h0000_0000;

  // Pins move one edge after a request, never on the sampling edge itself
  always @(posedge clk)
  begin
    term_in <= want;
  end
endmodule // csel_term_model

`default_nettype wire

// >>> dv/csel_top_tb.sv
// Self-checking bench for the control source selector.
// Assumes csel_pkg is compiled first and the design answers AXI4-Lite as noted.
`timescale 1ns/1ns
`default_nettype none

module csel_top_tb;
  logic clk = 1'b0; // 20 MHz clock
  logic reset = 1'b1; // Held high for 8 cycles
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1; // Always ready for answers
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, term_in, func_out;
  logic [31:0] term_want = 32'h0000_0000; // Levels asked of the terminal model
  logic output_halt, link_refused;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  // Clock generator
  always #25 clk = ~clk;

  csel_term_model i_csel_term_model (.clk(clk), .want(term_want), .term_in(term_in));

  csel_top i_csel_top (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .term_in(term_in),
    .func_out(func_out), .output_halt(output_halt), .link_refused(link_refused)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard

  // Prints the counts and the verdict, then stops
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected several hundred cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  // Compares one result word, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      mismatches++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master tasks

  // One write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1)
        aw_done = 1'b1;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        w_done = 1'b1;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  // One read: address held until taken, data taken at the rvalid edge
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Expected routing worked out from the selection rules

  function automatic logic [31:0] exp_route(input csel_pkg::csel_cfg_s f,
                                            input logic [31:0] cmd, input logic [31:0] trm);
    logic [31:0] e;
    e = 32'h0000_0000;
    for (int c = 0; c < 32; c++)
    begin
      case (c)
        7, 10, 11, 12, 16: e[c] = trm[c];
        8, 14: e[c] = f.speed_source_select ? trm[c] : cmd[c];
        3, 9, 13, 15, 17, 18, 19, 20, 22, 23: e[c] = f.operation_source_select ? trm[c] : cmd[c];
        0, 1, 2:
        begin
          if (f.operation_mode_param == 3'h5)
            e[c] = 1'b0;
          else if (f.speed_source_select)
            e[c] = trm[c];
          else if (c == 0 && (f.stop_on_contact_mode == 2'h1 || f.stop_on_contact_mode == 2'h3))
            e[c] = cmd[c];
          else if (f.remote_setting_mode == 2'h1 || f.remote_setting_mode == 2'h2)
            e[c] = cmd[c];
          else
            e[c] = cmd[c] | (f.multi_speed_compensation & trm[c]);
        end
        default: e[c] = 1'b0;
      endcase
    end
    return e;
  endfunction

  // Expected halt from both requests, polarity and the terminal-only overrides
  function automatic logic exp_halt(input csel_pkg::csel_cfg_s f, input logic h, input logic t);
    if (f.operation_source_select || (f.regen_converter_select == 2'h2 && !f.run_enable_assigned)
        || (f.operation_mode_param == 3'h7 && !f.interlock_assigned))
      return t;
    return (f.halt_polarity_select == 2'h2) ? !(h && t) : (h || t);
  endfunction

  // Applies a setting live, then four command and terminal patterns
  task automatic sweep(input logic [15:0] cfg);
    logic [31:0] cmds[4] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0F0F_5A5A};
    logic [31:0] trms[4] = '{32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 32'h33CC_A5C3};
    logic [1:0] r;
    axi_wr(csel_pkg::OFF_CFG, {16'h0000, cfg}, r);
    chk({30'h0, r}, {30'h0, csel_pkg::RESP_OK});
    for (int p = 0; p < 4; p++)
    begin
      axi_wr(csel_pkg::OFF_CMD, cmds[p], r);
      term_want <= trms[p];
      repeat (5) @(posedge clk); // Model, two sync stages and output take four edges
      chk(func_out, exp_route(cfg, cmds[p], trms[p]));
      chk({31'h0, output_halt}, {31'h0, exp_halt(cfg, cmds[p][24], trms[p][24])});
      chk({31'h0, link_refused}, {31'h0, cfg[6:4] == 3'h5});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios

  // Settings and host commands come up on the host source
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(csel_pkg::OFF_CFG, d, r);
    chk(d, 32'h0000_0000);
    axi_rd(csel_pkg::OFF_CMD, d, r);
    chk(d, 32'h0000_0000);
    chk(func_out, 32'h0000_0000);
  endtask

  // All four source combinations, switched without a restart
  task automatic t_sources;
    for (int s = 0; s < 4; s++)
      sweep(16'(s));
  endtask

  // Compensation, remote setting, programmed operation, stop-on-contact
  task automatic t_modes;
    logic [15:0] list[9] = '{16'h0200, 16'h0204, 16'h0206, 16'h0058, 16'h0051, 16'h0081,
                             16'h0182, 16'h0280, 16'h0208};
    foreach (list[i])
      sweep(list[i]);
  endtask

  // Halt polarity and the terminal-only overrides
  task automatic t_halt;
    logic [15:0] list[6] = '{16'h0000, 16'h2000, 16'h0800, 16'h4800, 16'h2070, 16'h8070};
    foreach (list[i])
      sweep(list[i]);
  endtask

  // Read-only store refused; routed and flag words read back in program mode
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(csel_pkg::OFF_CFG, 32'h0000_0058, r);
    axi_wr(csel_pkg::OFF_CMD, 32'hFFFF_FFFF, r);
    term_want <= 32'h33CC_A5C3;
    repeat (5) @(posedge clk); // Model, two sync stages and output take four edges
    axi_wr(csel_pkg::OFF_ROUTED, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, {30'h0, csel_pkg::RESP_DECERR});
    axi_rd(csel_pkg::OFF_ROUTED, d, r);
    chk(d, exp_route(16'h0058, 32'hFFFF_FFFF, 32'h33CC_A5C3));
    chk({30'h0, r}, {30'h0, csel_pkg::RESP_OK});
    axi_rd(csel_pkg::OFF_FLAG, d, r);
    chk(d, {30'h0, 1'b1, exp_halt(16'h0058, 1'b1, 1'b1)});
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_sources();
    t_modes();
    t_halt();
    t_bus();
    end_of_test();
  end
endmodule // csel_top_tb

`default_nettype wire
